// *** logic/aicc_input_cal_regs.sv ***
// Summary of operation
// - Three-bit charge-pump trim, default nominal code three.
// - Dual modes: swap bit crosses the inputs.
// - Swap bit ignored in single-channel modes.
// - Single select: A default, B, or DES.
// - Single select ignored outside single-channel modes.
// - Mux changes apply only when calibration runs.
// - Run bit high runs, low holds calibration.
// - Clearing run bit also resets clock dividers.
// - Background offset valid only with background calibration.
// - Foreground offset valid only with foreground calibration.
// - Background calibration enable bit, default off.
// - Foreground bit: reset values, optionally run foreground.
`timescale 1ns/1ns
`default_nettype none

module aicc_input_cal_regs
  import aicc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state held elsewhere
  input wire logic singleChannelMode,
  input wire logic serialLinkOutputEnable,
  // PLL control
  output logic [2:0] chargePumpTrim,
  // Input routing in force
  output logic channelASource,
  output logic channelBSource,
  // Calibration control
  output logic calibrationEnable,
  output logic calibrationHoldReset,
  output logic clockDividerReset,
  output logic calValuesReset,
  output logic foregroundCalStart,
  output logic foregroundCalRun,
  output logic backgroundCalEnable,
  output logic foregroundOffsetCalEnable,
  output logic backgroundOffsetCalEnable,
  // Sequencing status
  output logic linkOrderError
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  // The eight-bit index field spans address bits 9:2; APB addresses are at most 32.
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
    $error("aicc_input_cal_regs: ADDR_W must lie between 10 and 32");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pllCp;
    logic [7:0] inputSel;
    logic [7:0] calRun;
    logic [7:0] calCfg;
    logic [7:0] rdata;
    logic calRunDly;
    logic linkEnDly;
    logic srcA;
    logic srcB;
    logic orderErr;
    logic startPulse;
    logic fgStartPulse;
  } aicc_state_type;

  localparam aicc_state_type STATE_RESET = '{
    pllCp: RST_PLL_CP,
    inputSel: RST_INPUT_SEL,
    calRun: RST_CAL_RUN,
    calCfg: RST_CAL_CFG,
    rdata: 8'h00,
    calRunDly: 1'b0,
    linkEnDly: 1'b0,
    srcA: SRC_INPUT_A,
    srcB: SRC_INPUT_B,
    orderErr: 1'b0,
    startPulse: 1'b0,
    fgStartPulse: 1'b0
  };

  aicc_state_type state;
  aicc_state_type next_state;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Each register fills one aligned word; anything else is unmapped.
  function automatic aicc_sel_type decodeSel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] upper;
    logic [7:0] idx;
    upper = addr >> 10;
    idx = addr[9:2];
    decodeSel = SEL_NONE;
    if (upper == '0 && addr[1:0] == 2'h0) begin
      case (idx)
        IDX_PLL_CP: decodeSel = SEL_PLL_CP;
        IDX_INPUT_SEL: decodeSel = SEL_INPUT_SEL;
        IDX_CAL_RUN: decodeSel = SEL_CAL_RUN;
        IDX_CAL_CFG: decodeSel = SEL_CAL_CFG;
        IDX_STATUS: decodeSel = SEL_STATUS;
        default: decodeSel = SEL_NONE;
      endcase
    end
  endfunction

  aicc_sel_type accessSel;
  logic accessPhase;
  logic setupRead;
  logic writeLow;
  logic calStart;
  logic routeA;
  logic routeB;
  logic [7:0] statusWord;
  logic [7:0] readWord;

  assign accessSel = decodeSel(paddr);
  assign accessPhase = psel && penable;
  assign setupRead = psel && !penable && !pwrite;
  // Only the low byte lane carries register bits; upper lanes are ignored.
  assign writeLow = accessPhase && pwrite && pstrb[0];

  // The slave never inserts wait states: read data is staged in the setup cycle.
  assign pready = accessPhase;
  assign pslverr = accessPhase && (accessSel == SEL_NONE);
  assign prdata = {24'h000000, state.rdata};

  // ---------------------------------------------------------------------------
  // Input routing
  // ---------------------------------------------------------------------------
  aicc_route u_route (
    .singleChannelMode(singleChannelMode),
    .singleSelect(state.inputSel[SINGLE_SEL_LSB +: 2]),
    .dualSwap(state.inputSel[DUAL_SWAP_BIT]),
    .channelASource(routeA),
    .channelBSource(routeB)
  );

  // A calibration run begins on the rising edge of the run bit, including the
  // first cycle after reset, since the run bit resets high.
  assign calStart = state.calRun[CAL_RUN_BIT] && !state.calRunDly;

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb begin
    statusWord = 8'h00;
    statusWord[ST_CAL_RUN_BIT] = state.calRun[CAL_RUN_BIT];
    statusWord[ST_SRC_A_BIT] = state.srcA;
    statusWord[ST_SRC_B_BIT] = state.srcB;
    statusWord[ST_ORDER_ERR_BIT] = state.orderErr;
    case (accessSel)
      SEL_PLL_CP: readWord = state.pllCp;
      SEL_INPUT_SEL: readWord = state.inputSel;
      SEL_CAL_RUN: readWord = state.calRun;
      SEL_CAL_CFG: readWord = state.calCfg;
      SEL_STATUS: readWord = statusWord;
      default: readWord = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.calRunDly = state.calRun[CAL_RUN_BIT];
    next_state.linkEnDly = serialLinkOutputEnable;
    next_state.startPulse = calStart;
    next_state.fgStartPulse = calStart && state.calCfg[FG_CAL_BIT];

    if (setupRead) begin
      next_state.rdata = readWord;
    end

    if (writeLow) begin
      case (accessSel)
        // Reserved bits of the four control registers are read/write storage; status is not.
        SEL_PLL_CP: next_state.pllCp = pwdata[7:0];
        SEL_INPUT_SEL: next_state.inputSel = pwdata[7:0];
        SEL_CAL_RUN: next_state.calRun = pwdata[7:0];
        SEL_CAL_CFG: next_state.calCfg = pwdata[7:0];
        SEL_STATUS: begin
          if (pwdata[ST_ORDER_ERR_BIT]) begin
            next_state.orderErr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // The mux settings are latched only when a calibration starts, so a write
    // to the select register alone never disturbs a running conversion.
    if (calStart) begin
      next_state.srcA = routeA;
      next_state.srcB = routeB;
    end

    // Sequencing violations by the host are flagged, not corrected; the set
    // term comes last so an event in the clearing cycle is kept.
    if (state.calRunDly && !state.calRun[CAL_RUN_BIT] && serialLinkOutputEnable) begin
      next_state.orderErr = 1'b1;
    end
    if (serialLinkOutputEnable && !state.linkEnDly && !state.calRun[CAL_RUN_BIT]) begin
      next_state.orderErr = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign chargePumpTrim = state.pllCp[CP_TRIM_LSB +: CP_TRIM_W];
  assign channelASource = state.srcA;
  assign channelBSource = state.srcB;
  assign calibrationEnable = state.calRun[CAL_RUN_BIT];
  assign calibrationHoldReset = !state.calRun[CAL_RUN_BIT];
  // Clearing the run bit also stops the digital and serial-output dividers.
  assign clockDividerReset = !state.calRun[CAL_RUN_BIT];
  assign calValuesReset = state.startPulse;
  assign foregroundCalStart = state.fgStartPulse;
  assign foregroundCalRun = state.calCfg[FG_CAL_BIT];
  assign backgroundCalEnable = state.calCfg[BG_CAL_BIT];
  assign foregroundOffsetCalEnable =
    state.calCfg[FG_OFFSET_BIT] && state.calCfg[FG_CAL_BIT];
  assign backgroundOffsetCalEnable =
    state.calCfg[BG_OFFSET_BIT] && state.calCfg[BG_CAL_BIT];
  assign linkOrderError = state.orderErr;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb_main @(posedge mclk);
  endclocking

  default disable iff (rst);

  sequence s_calRise;
    !calibrationEnable ##1 calibrationEnable;
  endsequence

  sequence s_startPulse;
    calValuesReset ##1 !calValuesReset;
  endsequence

  sequence s_cfgWrite;
    writeLow && accessSel == SEL_CAL_CFG;
  endsequence

  a_trim_default: assert property (
    $fell(rst) |-> chargePumpTrim == RST_CP_TRIM
  ) else $error("charge-pump trim not at nominal after reset");

  a_trim_write: assert property (
    (writeLow && accessSel == SEL_PLL_CP)
      |=> chargePumpTrim == $past(pwdata[2:0])
  ) else $error("charge-pump trim did not take the written code");

  a_swap_route: assert property (
    (calStart && !singleChannelMode)
      |=> (channelASource == $past(state.inputSel[DUAL_SWAP_BIT]))
        && (channelBSource != $past(state.inputSel[DUAL_SWAP_BIT]))
  ) else $error("dual-channel routing does not follow the swap bit");

  a_single_route: assert property (
    (calStart && singleChannelMode && state.inputSel[1:0] == SINGLE_INPUT_B)
      |=> channelASource == SRC_INPUT_B && channelBSource == SRC_INPUT_B
  ) else $error("single-channel input B not routed to both channels");

  a_mux_deferred: assert property (
    !calStart |=> $stable(channelASource) && $stable(channelBSource)
  ) else $error("input routing changed without a calibration start");

  a_cal_hold: assert property (
    (writeLow && accessSel == SEL_CAL_RUN && !pwdata[CAL_RUN_BIT])
      |=> clockDividerReset && calibrationHoldReset && !calibrationEnable
  ) else $error("dividers or calibration not held after the run bit was cleared");

  a_run_write: assert property (
    (writeLow && accessSel == SEL_CAL_RUN)
      |=> calibrationEnable == $past(pwdata[CAL_RUN_BIT])
  ) else $error("run bit did not take the written value");

  a_cal_start: assert property (
    s_calRise |=> s_startPulse
  ) else $error("calibration start pulse missing or longer than one cycle");

  a_fg_start: assert property (
    calValuesReset |-> foregroundCalStart == $past(foregroundCalRun)
  ) else $error("foreground start does not follow the foreground bit");

  a_bgos_gate: assert property (
    s_cfgWrite |=> backgroundOffsetCalEnable
      == ($past(pwdata[BG_OFFSET_BIT]) && $past(pwdata[BG_CAL_BIT]))
  ) else $error("background offset enable does not follow its gated bits");

  a_fgos_gate: assert property (
    s_cfgWrite |=> foregroundOffsetCalEnable
      == ($past(pwdata[FG_OFFSET_BIT]) && $past(pwdata[FG_CAL_BIT]))
  ) else $error("foreground offset enable does not follow its gated bits");

  a_strobe_gate: assert property (
    (accessPhase && pwrite && !pstrb[0] && accessSel == SEL_PLL_CP)
      |=> $stable(chargePumpTrim)
  ) else $error("charge-pump trim changed on a write without the low byte lane");

  a_order_late: assert property (
    (serialLinkOutputEnable && !$past(serialLinkOutputEnable) && !calibrationEnable)
      |=> linkOrderError
  ) else $error("link enabled before the run bit was not flagged");

  a_flag_clear: assert property (
    (writeLow && accessSel == SEL_STATUS && pwdata[ST_ORDER_ERR_BIT]
      && !serialLinkOutputEnable) |=> !linkOrderError
  ) else $error("order flag not cleared by its write-one-to-clear");

  a_order_flag: assert property (
    ($fell(calibrationEnable) && serialLinkOutputEnable) |=> linkOrderError
  ) else $error("run bit cleared under live link was not flagged");

endmodule // aicc_input_cal_regs

`default_nettype wire

// *** logic/aicc_pkg.sv ***
`default_nettype none

package aicc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_PLL_CP = 8'h4f;
  localparam logic [7:0] IDX_INPUT_SEL = 8'h60;
  localparam logic [7:0] IDX_CAL_RUN = 8'h61;
  localparam logic [7:0] IDX_CAL_CFG = 8'h62;
  localparam logic [7:0] IDX_STATUS = 8'h5f;

  // ---------------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_PLL_CP = 8'h13;
  localparam logic [7:0] RST_INPUT_SEL = 8'h01;
  localparam logic [7:0] RST_CAL_RUN = 8'h01;
  localparam logic [7:0] RST_CAL_CFG = 8'h01;
  localparam logic [2:0] RST_CP_TRIM = 3'h3;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int unsigned CP_TRIM_LSB = 0;
  localparam int unsigned CP_TRIM_W = 3;
  localparam logic [2:0] CP_TRIM_MAX = 3'h7;
  localparam int unsigned DUAL_SWAP_BIT = 4;
  localparam int unsigned SINGLE_SEL_LSB = 0;
  localparam int unsigned CAL_RUN_BIT = 0;
  localparam int unsigned BG_OFFSET_BIT = 3;
  localparam int unsigned FG_OFFSET_BIT = 2;
  localparam int unsigned BG_CAL_BIT = 1;
  localparam int unsigned FG_CAL_BIT = 0;
  localparam int unsigned ST_CAL_RUN_BIT = 0;
  localparam int unsigned ST_SRC_A_BIT = 1;
  localparam int unsigned ST_SRC_B_BIT = 2;
  localparam int unsigned ST_ORDER_ERR_BIT = 3;

  // ---------------------------------------------------------------------------
  // Encodings.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SINGLE_RESERVED = 2'h0;
  localparam logic [1:0] SINGLE_INPUT_A = 2'h1;
  localparam logic [1:0] SINGLE_INPUT_B = 2'h2;
  localparam logic [1:0] SINGLE_DES = 2'h3;
  localparam logic SRC_INPUT_A = 1'b0;
  localparam logic SRC_INPUT_B = 1'b1;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PLL_CP,
    SEL_INPUT_SEL,
    SEL_CAL_RUN,
    SEL_CAL_CFG,
    SEL_STATUS
  } aicc_sel_type;

endpackage

`default_nettype wire

// *** logic/aicc_route.sv ***
`timescale 1ns/1ns
`default_nettype none

module aicc_route
  import aicc_pkg::*;
(
  // Mode and mux settings
  input wire logic singleChannelMode,
  input wire logic [1:0] singleSelect,
  input wire logic dualSwap,
  // Analog input that each channel samples
  output logic channelASource,
  output logic channelBSource
);

  always_comb begin
    channelASource = SRC_INPUT_A;
    channelBSource = SRC_INPUT_B;
    if (singleChannelMode) begin
      case (singleSelect)
        SINGLE_INPUT_B: begin
          channelASource = SRC_INPUT_B;
          channelBSource = SRC_INPUT_B;
        end
        SINGLE_DES: begin
          channelASource = SRC_INPUT_A;
          channelBSource = SRC_INPUT_B;
        end
        // The reserved code falls back to input A rather than an undefined route.
        default: begin
          channelASource = SRC_INPUT_A;
          channelBSource = SRC_INPUT_A;
        end
      endcase
    end else if (dualSwap) begin
      channelASource = SRC_INPUT_B;
      channelBSource = SRC_INPUT_A;
    end
  end

endmodule // aicc_route

`default_nettype wire

// *** bench/test_adc_input_cal_control.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_adc_input_cal_control
  import aicc_pkg::*;
();
  // ---------------------------------------------------------------
  // Stimulus, expectations and the design
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic singleMode = 1'b0;
  logic linkEnable = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, srcA, srcB, calEn, holdRst, divRst, valRst, fgStart;
  logic fgRun, bgEn, fgOs, bgOs, orderErr;
  logic [2:0] trim;
  logic [33:0] noteQ[$];
  logic [33:0] note;
  logic [31:0] seed = 32'h0000837e;
  logic expA = 1'b0;
  logic expB = 1'b1;
  int failCount = 0;
  int totalChecks = 0;

  always #50 mclk = ~mclk;

  aicc_input_cal_regs dut_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .singleChannelMode(singleMode), .serialLinkOutputEnable(linkEnable),
    .chargePumpTrim(trim), .channelASource(srcA), .channelBSource(srcB),
    .calibrationEnable(calEn), .calibrationHoldReset(holdRst), .clockDividerReset(divRst),
    .calValuesReset(valRst), .foregroundCalStart(fgStart), .foregroundCalRun(fgRun),
    .backgroundCalEnable(bgEn), .foregroundOffsetCalEnable(fgOs),
    .backgroundOffsetCalEnable(bgOs), .linkOrderError(orderErr)
  );

  function automatic logic [11:0] byteAddr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The note is queued before the request so the watcher always finds it.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] exp);
    int n;
    noteQ.push_back({w, err, exp});
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("pready wait", 32'h0, 32'h1);
      tally_and_finish();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    xfer(1'b1, a, d, err, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0, err, exp);
  endtask

  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (noteQ.size() == 0) begin
        check("note queue", 32'h0, 32'h1);
      end else begin
        note = noteQ.pop_front();
        check("pslverr", 32'(pslverr), 32'(note[32]));
        if (note[33] == 1'b0) check("prdata", prdata, note[31:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    check("run time", 32'h0, 32'h1);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [3:0] cfg;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check("trim", 32'(trim), 32'h3);
    check("run", 32'({calEn, holdRst, divRst}), 32'h4);
    check("cal cfg", 32'({bgOs, fgOs, bgEn, fgRun}), 32'h1);
    check("sources", 32'({srcA, srcB}), 32'h1);
    rd(byteAddr(IDX_PLL_CP), 32'(RST_PLL_CP), 1'b0);
    rd(byteAddr(IDX_INPUT_SEL), 32'(RST_INPUT_SEL), 1'b0);
    rd(byteAddr(IDX_CAL_RUN), 32'(RST_CAL_RUN), 1'b0);
    rd(byteAddr(IDX_CAL_CFG), 32'(RST_CAL_CFG), 1'b0);
    rd(byteAddr(IDX_STATUS), 32'h5, 1'b0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      wr(byteAddr(IDX_PLL_CP), {r[31:3], 3'(c)}, 1'b0);
      check("trim", 32'(trim), 32'(c));
      rd(byteAddr(IDX_PLL_CP), {24'h0, r[7:3], 3'(c)}, 1'b0);
    end
    @(posedge mclk);
    pstrb <= 4'he;
    wr(byteAddr(IDX_PLL_CP), 32'h0, 1'b0);
    check("trim kept", 32'(trim), 32'(CP_TRIM_MAX));
    @(posedge mclk);
    pstrb <= 4'hf;
    rd(12'h000, 32'h0, 1'b1);
    wr(12'h190, 32'h0, 1'b1);
    rd(12'h181, 32'h0, 1'b1);
    $display("test trim and decode done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      cfg = r[3:0];
      wr(byteAddr(IDX_CAL_RUN), 32'h0, 1'b0);
      check("held", 32'({calEn, holdRst, divRst}), 32'h3);
      @(posedge mclk);
      singleMode <= i[2];
      wr(byteAddr(IDX_INPUT_SEL), {27'h0, i[0], 2'h0, i[1:0]}, 1'b0);
      wr(byteAddr(IDX_CAL_CFG), {28'h0, cfg}, 1'b0);
      check("no early route", 32'({srcA, srcB}), 32'({expA, expB}));
      check("cal levels", 32'({bgOs, fgOs, bgEn, fgRun}),
            32'({cfg[3] & cfg[1], cfg[2] & cfg[0], cfg[1], cfg[0]}));
      if (i[2] == 1'b0) {expA, expB} = i[0] ? 2'b10 : 2'b01;
      else if (i[1:0] == 2'h2) {expA, expB} = 2'b11;
      else if (i[1:0] == 2'h3) {expA, expB} = 2'b01;
      else {expA, expB} = 2'b00;
      wr(byteAddr(IDX_CAL_RUN), 32'h1, 1'b0);
      check("released", 32'({calEn, holdRst, divRst, valRst}), 32'h8);
      @(posedge mclk);
      #1;
      check("start", 32'({valRst, fgStart}), 32'({1'b1, cfg[0]}));
      check("route", 32'({srcA, srcB}), 32'({expA, expB}));
      @(posedge mclk);
      #1;
      check("start end", 32'({valRst, fgStart}), 32'h0);
      rd(byteAddr(IDX_STATUS), 32'({1'b0, expB, expA, 1'b1}), 1'b0);
    end
    $display("test routing and calibration done");
    @(posedge mclk);
    linkEnable <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("order ok", 32'(orderErr), 32'h0);
    wr(byteAddr(IDX_CAL_RUN), 32'h0, 1'b0);
    @(posedge mclk);
    #1;
    check("order flag", 32'(orderErr), 32'h1);
    rd(byteAddr(IDX_STATUS), 32'({1'b1, expB, expA, 1'b0}), 1'b0);
    @(posedge mclk);
    linkEnable <= 1'b0;
    wr(byteAddr(IDX_STATUS), 32'h8, 1'b0);
    check("flag cleared", 32'(orderErr), 32'h0);
    @(posedge mclk);
    linkEnable <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("order flag", 32'(orderErr), 32'h1);
    @(posedge mclk);
    linkEnable <= 1'b0;
    wr(byteAddr(IDX_CAL_RUN), 32'h1, 1'b0);
    wr(byteAddr(IDX_STATUS), 32'h8, 1'b0);
    rd(byteAddr(IDX_STATUS), 32'({1'b0, expB, expA, 1'b1}), 1'b0);
    $display("test link order done");
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule // test_adc_input_cal_control

`default_nettype wire
